//--- flash_clock_divider.sv
// Programmable divider that makes the flash clock and its half-period ticks.
`timescale 1ns/1ps

module flash_clock_divider
    import nand_timing_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // Divisor setting
    input  wire logic [DIV_W-1:0] divisorIn,
    input  wire logic             divisorLoad,
    output logic                  divisorReject,
    // Flash clock events
    output logic                  halfTick,
    output logic                  periodTick,
    output logic                  flashClk
);

    div_state_t s;
    div_state_t next_s;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // A new divisor waits for a period boundary, so no flash period is ever cut short.
    always_comb begin
        next_s            = s;
        next_s.halfTick   = 1'b0;
        next_s.periodTick = 1'b0;
        next_s.reject     = 1'b0;
        if (s.count == s.divisor - 8'h01) begin // [RL1]
            next_s.count      = 8'h00;
            next_s.periodTick = 1'b1;
            next_s.flashClk   = 1'b1;
            if (s.pendingValid) begin
                next_s.divisor      = s.pendingDiv;
                next_s.pendingValid = 1'b0;
            end
        end else begin
            next_s.count = s.count + 8'h01;
            if (s.count == (s.divisor >> 1) - 8'h01) begin
                next_s.halfTick = 1'b1;
                next_s.flashClk = 1'b0;
            end
        end
        if (divisorLoad) begin
            if (divisorIn >= MIN_DIV) begin // [RL2]
                next_s.pendingDiv   = divisorIn;
                next_s.pendingValid = 1'b1;
            end else begin
                next_s.reject = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s            <= '0;
            s.divisor    <= DEFAULT_DIV; // [RL3]
            s.pendingDiv <= DEFAULT_DIV;
        end else begin
            s <= next_s;
        end
    end

    assign halfTick      = s.halfTick;
    assign periodTick    = s.periodTick;
    assign flashClk      = s.flashClk;
    assign divisorReject = s.reject;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_divisor_floor: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL2]
        s.divisor >= MIN_DIV)
        else $error("Active divisor is below the frequency floor.");

    chk_reject_low: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL2]
        divisorLoad && (divisorIn < MIN_DIV) |=> divisorReject && $stable(s.pendingDiv))
        else $error("Too small a divisor was not rejected.");

    chk_period_spacing: assert property (@(posedge sys_clk) disable iff (!resetn) // [RL1]
        periodTick |-> ##[2:255] halfTick)
        else $error("No half tick followed a period tick.");

endmodule // flash_clock_divider

//--- nand_flash_cycle_timing.sv
// Pin sequencer for command, address, write and read cycles toward a NAND flash.
`timescale 1ns/1ps

module nand_flash_cycle_timing
    import nand_timing_pkg::*;
(
    // Clock and reset
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    // Divider setting
    input  wire logic [DIV_W-1:0] divisorIn,
    input  wire logic             divisorLoad,
    output logic                  divisorReject,
    // Cycle request
    input  wire logic             reqValid,
    input  wire flash_req_t       req,
    output logic                  reqReady,
    // Read answer
    output logic [7:0]            readData,
    output logic                  readValid,
    // Flash pins
    output flash_pins_t           flashPins,
    output logic                  flashClk,
    input  wire logic [7:0]       flashDataIn,
    input  wire logic             flashReady
);

    // ------------------------------------------------------------------
    // Flash clock
    // ------------------------------------------------------------------
    logic halfTick;
    logic periodTick;
    logic halfEvt;

    flash_clock_divider u_divider (
        .sys_clk       (sys_clk),
        .resetn        (resetn),
        .divisorIn     (divisorIn),
        .divisorLoad   (divisorLoad),
        .divisorReject (divisorReject),
        .halfTick      (halfTick),
        .periodTick    (periodTick),
        .flashClk      (flashClk)
    );

    // Every pin edge lands on one of these, so all spans are half-period multiples.
    assign halfEvt = halfTick | periodTick; // [RL4]

    seq_state_t s;
    seq_state_t next_s;
    logic [3:0] phaseHalves;
    logic       phaseDone;

    // ------------------------------------------------------------------
    // Length of the present phase
    // ------------------------------------------------------------------
    always_comb begin
        unique case (s.phase)
            PH_IDLE:   phaseHalves = 4'h1;
            PH_SETUP:  phaseHalves = SETUP_HALVES;      // [RL6]
            PH_STROBE: phaseHalves = WE_LOW_HALVES;     // [RL6]
            PH_HOLD:   phaseHalves = HOLD_HALVES;       // [RL6]
            PH_RWAIT:  phaseHalves = READY_WAIT_HALVES; // [RL7]
            PH_RLOW:   phaseHalves = RE_LOW_HALVES;     // [RL7]
            PH_RHIGH:  phaseHalves = RE_HIGH_HALVES;    // [RL6]
            default:   phaseHalves = 4'h1;
        endcase
    end

    // The wait for ready only advances while the memory reports ready.
    assign phaseDone = halfEvt && (s.halves == phaseHalves - 4'h1)
                       && ((s.phase != PH_RWAIT) || flashReady); // [RL7]

    // Requests start only on a flash clock edge, keeping cycles aligned to it.
    assign reqReady = (s.phase == PH_IDLE) && halfEvt;

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s           = s;
        next_s.readValid = 1'b0;
        if (halfEvt && (s.phase != PH_IDLE)) begin
            if (phaseDone) begin
                next_s.halves = 4'h0;
            end else if ((s.phase != PH_RWAIT) || flashReady) begin
                next_s.halves = s.halves + 4'h1;
            end else begin
                next_s.halves = 4'h0;
            end
        end
        // A ready drop in any cycle, not only on a half edge, restarts the wait.
        if ((s.phase == PH_RWAIT) && !flashReady) begin
            next_s.halves = 4'h0; // [RL7]
        end
        unique case (s.phase)
            PH_IDLE: begin
                if (reqValid && reqReady) begin // [RL8]
                    next_s.halves                  = 4'h0;
                    next_s.pins.flashChipEnableN   = 1'b0;
                    next_s.pins.commandLatchEnable = (req.kind == CYC_COMMAND);
                    next_s.pins.addressLatchEnable = (req.kind == CYC_ADDRESS);
                    if (req.kind == CYC_READ) begin
                        next_s.pins.dataOeN = 1'b1;
                        next_s.phase        = PH_RWAIT;
                    end else begin
                        next_s.pins.dataOut = req.data;
                        next_s.pins.dataOeN = 1'b0;
                        next_s.phase        = PH_SETUP;
                    end
                end
            end
            PH_SETUP: begin
                if (phaseDone) begin
                    next_s.pins.flashWriteStrobeN = 1'b0; // [RL6]
                    next_s.phase                  = PH_STROBE;
                end
            end
            PH_STROBE: begin
                if (phaseDone) begin
                    next_s.pins.flashWriteStrobeN = 1'b1; // [RL7]
                    next_s.phase                  = PH_HOLD;
                end
            end
            PH_HOLD: begin
                // Latches, chip enable and data are held a full period past the strobe.
                if (phaseDone) begin
                    next_s.pins.commandLatchEnable = 1'b0; // [RL6]
                    next_s.pins.addressLatchEnable = 1'b0;
                    next_s.pins.flashChipEnableN   = 1'b1;
                    next_s.pins.dataOeN            = 1'b1;
                    next_s.phase                   = PH_IDLE;
                end
            end
            PH_RWAIT: begin
                if (phaseDone) begin
                    next_s.pins.flashReadStrobeN = 1'b0; // [RL7]
                    next_s.phase                 = PH_RLOW;
                end
            end
            PH_RLOW: begin
                // Sampling on the flash edge that ends the pulse gives the data
                // the whole 1.5 periods to settle, well past the absolute setup.
                if (phaseDone) begin
                    next_s.readData              = flashDataIn; // [RL5]
                    next_s.readValid             = 1'b1;
                    next_s.pins.flashReadStrobeN = 1'b1;
                    next_s.phase                 = PH_RHIGH;
                end
            end
            PH_RHIGH: begin
                if (phaseDone) begin
                    next_s.pins.flashChipEnableN = 1'b1;
                    next_s.phase                 = PH_IDLE;
                end
            end
            default: begin
                next_s.phase = PH_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s                        <= '0;
            s.phase                  <= PH_IDLE;
            s.pins.flashChipEnableN  <= 1'b1;
            s.pins.flashWriteStrobeN <= 1'b1;
            s.pins.flashReadStrobeN  <= 1'b1;
            s.pins.dataOeN           <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign flashPins = s.pins;
    assign readData  = s.readData;
    assign readValid = s.readValid;

    // ------------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------------
    logic [3:0] weLowHalves;
    logic [3:0] reLowHalves;
    logic [3:0] readyHalves;
    logic [9:0] reLowCycles;

    // Counts flash half periods with each strobe low and in the ready wait, and system cycles with the read strobe low.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            weLowHalves <= 4'h0;
            reLowHalves <= 4'h0;
            readyHalves <= 4'h0;
            reLowCycles <= 10'h000;
        end else begin
            if (s.pins.flashWriteStrobeN) begin
                weLowHalves <= 4'h0;
            end else if (halfEvt) begin
                weLowHalves <= weLowHalves + 4'h1;
            end
            if (s.pins.flashReadStrobeN) begin
                reLowHalves <= 4'h0;
                reLowCycles <= 10'h000;
            end else begin
                reLowCycles <= reLowCycles + 10'h001;
                if (halfEvt) begin
                    reLowHalves <= reLowHalves + 4'h1;
                end
            end
            if ((s.phase != PH_RWAIT) || !flashReady) begin
                readyHalves <= 4'h0;
            end else if (halfEvt && flashReady) begin
                readyHalves <= readyHalves + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    chk_we_pulse_len: assert property ($rose(flashPins.flashWriteStrobeN) |-> // [RL6]
        weLowHalves == WE_LOW_HALVES)
        else $error("Write strobe low time is not one period.");

    chk_re_pulse_len: assert property ($rose(flashPins.flashReadStrobeN) |-> // [RL7]
        reLowHalves == RE_LOW_HALVES && reLowCycles >= READ_SETUP_CYC)
        else $error("Read strobe low time is not one and a half periods.");

    chk_ready_wait: assert property ($fell(flashPins.flashReadStrobeN) |-> // [RL7]
        readyHalves == READY_WAIT_HALVES)
        else $error("Read strobe fell without four ready periods.");

    chk_capture_edge: assert property (readValid |-> // [RL5]
        $past(halfEvt) && $past(s.phase) == PH_RLOW && readData == $past(flashDataIn))
        else $error("Read data not captured at the end of the read pulse.");

    chk_pins_on_edges: assert property ($changed(flashPins) |-> $past(halfEvt)) // [RL4]
        else $error("A flash pin moved off a flash clock edge.");

    chk_strobe_framing: assert property (!flashPins.flashWriteStrobeN |-> // [RL8]
        !flashPins.flashChipEnableN && !flashPins.dataOeN && flashPins.flashReadStrobeN)
        else $error("Write strobe low outside an enabled write cycle.");

    chk_latch_hold: assert property ($rose(flashPins.flashWriteStrobeN) |-> // [RL6]
        (!flashPins.flashChipEnableN && $stable(flashPins.dataOut)) [*2])
        else $error("Chip enable or data released right after the write strobe.");

    chk_re_high_time: assert property ($rose(flashPins.flashReadStrobeN) |-> // [RL6]
        s.phase == PH_RHIGH ##1 (s.phase == PH_RHIGH) [*1])
        else $error("Read strobe high time shorter than half a period.");

endmodule // nand_flash_cycle_timing

//--- nand_flash_model.sv
// Behavioural NAND flash memory that answers the timing core's pin cycles.
`timescale 1ns/1ps

module nand_flash_model
    import nand_timing_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // Scenario controls
    input  wire logic [7:0]  busyCycles,
    input  wire logic        dropReady,
    input  wire logic [7:0]  nextByte,
    // Flash pins
    input  wire flash_pins_t flashPins,
    output logic [7:0]       flashDataIn,
    output logic             flashReady,
    // Last latched byte
    output cycle_kind_t      lastKind,
    output logic [7:0]       lastByte
);
    // ------------------------------------------------------------------
    // Memory behaviour
    // ------------------------------------------------------------------
    logic [7:0] busy;
    logic [7:0] run;
    logic       dropped;
    logic       prevCeN;
    logic       prevWeN;

    // Ready follows the busy count, so it can only change just after an edge.
    assign flashReady = (busy == 8'h00);

    // Busy after a read select, optional ready glitch, data and byte capture.
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 8'h00;
            run <= 8'h00;
            dropped <= 1'b0;
            prevCeN <= 1'b1;
            prevWeN <= 1'b1;
            flashDataIn <= 8'h00;
            lastKind <= CYC_COMMAND;
            lastByte <= 8'h00;
        end else begin
            prevCeN <= flashPins.flashChipEnableN;
            prevWeN <= flashPins.flashWriteStrobeN;
            run <= flashReady ? run + 8'h01 : 8'h00;
            if (prevCeN && !flashPins.flashChipEnableN && flashPins.dataOeN) begin
                busy <= busyCycles;
                dropped <= 1'b0;
            end else if (dropReady && !dropped && run == 8'h0a) begin
                busy <= 8'h03;
                dropped <= 1'b1;
            end else if (busy != 8'h00) begin
                busy <= busy - 8'h01;
            end
            // A released bus toggles so a stale byte can never be mistaken for data.
            if (!flashPins.flashChipEnableN && !flashPins.flashReadStrobeN) begin
                flashDataIn <= nextByte;
            end else begin
                flashDataIn <= ~flashDataIn;
            end
            if (!prevWeN && flashPins.flashWriteStrobeN && !flashPins.flashChipEnableN) begin
                lastByte <= flashPins.dataOut;
                lastKind <= flashPins.commandLatchEnable ? CYC_COMMAND :
                            (flashPins.addressLatchEnable ? CYC_ADDRESS : CYC_WRITE);
            end
        end
    end

endmodule // nand_flash_model

//--- nand_timing_pkg.sv
// Constants, types and carriers shared by the flash cycle timing core.
// Operation
// RL1 - Flash clock comes from the system clock through a programmable integer divider.
// RL2 - Divisors that would push the flash clock above 66 MHz are rejected.
// RL3 - Divider leaves reset at the value giving roughly 16.63 MHz.
// RL4 - Pin intervals are whole or half flash periods; read setup is 15 ns absolute.
// RL5 - Memory drives read data; it is captured at the flash edge ending the read pulse.
// RL6 - Latch, chip enable, data setup/hold and write pulse each last one period.
// RL7 - Cycles last two periods; read pulse 1.5 periods; four periods after ready.
// RL8 - Four cycle kinds: command, address, write data and read data.
package nand_timing_pkg;

    // ------------------------------------------------------------------
    // Clock and divider figures
    // ------------------------------------------------------------------
    localparam int        SYS_CLK_KHZ       = 250000;
    localparam int        MAX_FLASH_KHZ     = 66000;
    localparam int        DEFAULT_FLASH_KHZ = 16630;
    localparam int        DIV_W             = 8;
    // Smallest divisor whose flash clock stays at or below the ceiling.
    localparam logic [7:0] MIN_DIV     = 8'((SYS_CLK_KHZ + MAX_FLASH_KHZ - 1) / MAX_FLASH_KHZ);
    // Whole divisor for the power-up frequency, with the fraction dropped.
    localparam logic [7:0] DEFAULT_DIV = 8'(SYS_CLK_KHZ / DEFAULT_FLASH_KHZ);

    // ------------------------------------------------------------------
    // Pin timing, counted in half flash periods, except the read setup in ns and system cycles
    // ------------------------------------------------------------------
    localparam logic [3:0] SETUP_HALVES      = 4'h2;
    localparam logic [3:0] WE_LOW_HALVES     = 4'h2;
    localparam logic [3:0] HOLD_HALVES       = 4'h2;
    localparam logic [3:0] READY_WAIT_HALVES = 4'h8;
    localparam logic [3:0] RE_LOW_HALVES     = 4'h3;
    localparam logic [3:0] RE_HIGH_HALVES    = 4'h1;
    localparam int         READ_SETUP_NS     = 15;
    localparam logic [9:0] READ_SETUP_CYC    =
        10'((READ_SETUP_NS * SYS_CLK_KHZ + 999999) / 1000000);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CYC_COMMAND = 2'h0,
        CYC_ADDRESS = 2'h1,
        CYC_WRITE   = 2'h2,
        CYC_READ    = 2'h3
    } cycle_kind_t;

    typedef enum logic [2:0] {
        PH_IDLE   = 3'h0,
        PH_SETUP  = 3'h1,
        PH_STROBE = 3'h3,
        PH_HOLD   = 3'h2,
        PH_RWAIT  = 3'h6,
        PH_RLOW   = 3'h7,
        PH_RHIGH  = 3'h5
    } phase_t;

    typedef struct packed {
        cycle_kind_t kind;
        logic [7:0]  data;
    } flash_req_t;

    typedef struct packed {
        logic       commandLatchEnable;
        logic       addressLatchEnable;
        logic       flashChipEnableN;
        logic       flashWriteStrobeN;
        logic       flashReadStrobeN;
        logic [7:0] dataOut;
        logic       dataOeN;
    } flash_pins_t;

    typedef struct packed {
        logic [7:0] divisor;
        logic [7:0] pendingDiv;
        logic       pendingValid;
        logic [7:0] count;
        logic       halfTick;
        logic       periodTick;
        logic       reject;
        logic       flashClk;
    } div_state_t;

    typedef struct packed {
        phase_t      phase;
        logic [3:0]  halves;
        flash_pins_t pins;
        logic [7:0]  readData;
        logic        readValid;
    } seq_state_t;

endpackage

//--- testbench.sv
// Self-checking bench for the flash cycle timing core and its memory model.
`timescale 1ns/1ps

module testbench;
    import nand_timing_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    localparam flash_pins_t RESET_PINS = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'h00, 1'b1};
    logic             sys_clk;
    logic             resetn;
    logic [DIV_W-1:0] divisorIn;
    logic             divisorLoad;
    logic             divisorReject;
    logic             reqValid;
    flash_req_t       req;
    logic             reqReady;
    logic [7:0]       readData;
    logic             readValid;
    flash_pins_t      flashPins;
    logic             flashClk;
    logic [7:0]       flashDataIn;
    logic             flashReady;
    logic [7:0]       busyCycles;
    logic             dropReady;
    logic [7:0]       nextByte;
    cycle_kind_t      lastKind;
    logic [7:0]       lastByte;
    int               failures;
    int               check_count;
    int               p;

    nand_flash_cycle_timing i_nand_flash_cycle_timing (
        .sys_clk(sys_clk), .resetn(resetn), .divisorIn(divisorIn),
        .divisorLoad(divisorLoad), .divisorReject(divisorReject), .reqValid(reqValid),
        .req(req), .reqReady(reqReady), .readData(readData), .readValid(readValid),
        .flashPins(flashPins), .flashClk(flashClk), .flashDataIn(flashDataIn),
        .flashReady(flashReady));

    nand_flash_model i_nand_flash_model (
        .sys_clk(sys_clk), .resetn(resetn), .busyCycles(busyCycles), .dropReady(dropReady),
        .nextByte(nextByte), .flashPins(flashPins), .flashDataIn(flashDataIn),
        .flashReady(flashReady), .lastKind(lastKind), .lastByte(lastByte));

    // Free-running 250 MHz system clock.
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (failures == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic timed_out(input string name);
        failures++;
        $display("unexpected %s: expected done seen timeout", name);
        report_and_stop();
    endtask

    // Inputs change and outputs are judged at the falling edge, away from sampling.
    task automatic tick();
        @(negedge sys_clk);
    endtask

    // Counts system cycles between two rising flash clock edges.
    task automatic measure_period(output int cnt);
        int   n;
        logic prev;
        n = 0;
        cnt = 0;
        prev = flashClk;
        while (!(flashClk === 1'b1 && prev === 1'b0)) begin
            prev = flashClk;
            tick();
            n++;
            if (n > 100) timed_out("flash clock edge");
        end
        do begin
            prev = flashClk;
            tick();
            cnt++;
        end while (!(flashClk === 1'b1 && prev === 1'b0) && cnt < 100);
        if (cnt >= 100) timed_out("flash clock period");
    endtask

    // One load pulse, then the one-cycle refusal pulse is counted.
    task automatic load_div(input logic [7:0] d, input int expRej);
        int rej;
        rej = 0;
        divisorIn = d;
        divisorLoad = 1'b1;
        tick();
        divisorLoad = 1'b0;
        repeat (3) begin
            if (divisorReject === 1'b1) rej++;
            tick();
        end
        check("divisor reject pulses", 32'(rej), 32'(expRej));
    endtask

    // Issues one cycle and times its pins in system cycles; h is half a flash period.
    task automatic run_cycle(input cycle_kind_t kind, input logic [7:0] data, input int h);
        int          setupCnt = 0;
        int          lowCnt = 0;
        int          tailCnt = 0;
        int          rdyCnt = 0;
        int          rdyAtFall = 0;
        int          valids = 0;
        int          n = 0;
        logic        isRead;
        logic        strobeN;
        logic        seenLow = 1'b0;
        flash_pins_t atFall;
        isRead = (kind == CYC_READ);
        nextByte = data;
        req = '{kind, data};
        reqValid = 1'b1;
        while (reqReady !== 1'b1) begin
            tick();
            n++;
            if (n > 100) timed_out("request taken");
        end
        tick();
        reqValid = 1'b0;
        for (n = 0; n < 400; n++) begin
            strobeN = isRead ? flashPins.flashReadStrobeN : flashPins.flashWriteStrobeN;
            rdyCnt = (flashReady === 1'b1) ? rdyCnt + 1 : 0;
            if (readValid === 1'b1) valids++;
            if (strobeN === 1'b0) begin
                if (!seenLow) atFall = flashPins;
                if (!seenLow) rdyAtFall = rdyCnt;
                seenLow = 1'b1;
                lowCnt++;
            end else if (flashPins.flashChipEnableN === 1'b0) begin
                if (seenLow) tailCnt++;
                else setupCnt++;
            end
            if (seenLow && flashPins.flashChipEnableN === 1'b1) break;
            tick();
        end
        if (n >= 400) timed_out("cycle end");
        check("strobe low", 32'(lowCnt), 32'(isRead ? 3 * h : 2 * h));
        check("strobe high to release", 32'(tailCnt), 32'(isRead ? h : 2 * h));
        check("bus driven", 32'(atFall.dataOeN), 32'(isRead));
        if (isRead) begin
            check("ready wait", 32'(rdyAtFall >= 7 * h && rdyAtFall <= 8 * h + 2), 1);
            check("read pulses", 32'(valids), 1);
            check("read byte", 32'(readData), 32'(data));
        end else begin
            check("setup", 32'(setupCnt), 32'(2 * h));
            check("command latch", 32'(atFall.commandLatchEnable), 32'(kind == CYC_COMMAND));
            check("address latch", 32'(atFall.addressLatchEnable), 32'(kind == CYC_ADDRESS));
            check("write byte", 32'(atFall.dataOut), 32'(data));
            check("latched byte", 32'(lastByte), 32'(data));
            check("latched kind", 32'(lastKind), 32'(kind));
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        resetn = 1'b0;
        divisorIn = 8'h00;
        divisorLoad = 1'b0;
        reqValid = 1'b0;
        req = '{CYC_COMMAND, 8'h00};
        busyCycles = 8'h05;
        dropReady = 1'b0;
        nextByte = 8'h00;
        failures = 0;
        check_count = 0;
        repeat (8) tick();
        check("pins in reset", 32'(flashPins), 32'(RESET_PINS));
        repeat (8) tick();
        resetn = 1'b1;
        check("flash clock after reset", 32'(flashClk), 0);
        measure_period(p);
        // Nearest whole divisor to the power-up frequency.
        check("power-up period", 32'(p), 32'((250000 + 8315) / 16630));
        load_div(8'h03, 1);
        load_div(8'h04, 0);
        repeat (20) tick();
        measure_period(p);
        check("fastest period", 32'(p), 4);
        run_cycle(CYC_READ, 8'h5a, 2);
        load_div(8'h08, 0);
        repeat (20) tick();
        measure_period(p);
        check("slow period", 32'(p), 8);
        // Back to back, so each request waits out the previous cycle.
        for (int k = 0; k < 3; k++) begin
            run_cycle(cycle_kind_t'(k), 8'h3c ^ 8'(k * 17), 4);
        end
        // The ready glitch must restart the wait before the read strobe falls.
        dropReady = 1'b1;
        busyCycles = 8'h09;
        run_cycle(CYC_READ, 8'ha5, 4);
        resetn = 1'b0;
        #1;
        check("pins in second reset", 32'(flashPins), 32'(RESET_PINS));
        tick();
        resetn = 1'b1;
        measure_period(p);
        check("period after second reset", 32'(p), 15);
        report_and_stop();
    end

endmodule // testbench
